// [src/spf_frame.v]
// spf_frame.v: serial flash command framing and status/protection register
`timescale 1ns/1ps
`default_nettype none
`include "spf_consts.vh"

module spf_frame (
	// clock and reset
	input  wire        clk_i,
	input  wire        nrst_i,
	// serial pins
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire        si_i,
	input  wire        wp_n_i,
	output reg         so_o,
	output reg         so_oe_o,
	// array engine side
	input  wire        busy_i,
	input  wire        op_done_i,
	input  wire        pwr_cycle_i,
	output reg         op_go_o,
	output reg  [2:0]  op_kind_o,
	output reg  [23:0] op_addr_o,
	output reg  [7:0]  prog_data_o,
	output reg         prog_vld_o,
	output reg         crm_reset_o,
	output reg  [15:0] status_o
);

	// frame states
	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_OPC  = 6'b000010;
	localparam [5:0] ST_ADDR = 6'b000100;
	localparam [5:0] ST_DATA = 6'b001000;
	localparam [5:0] ST_STAT = 6'b010000;
	localparam [5:0] ST_SINK = 6'b100000;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection

	reg  [3:0] sync1_q;
	reg  [3:0] sync2_q;
	reg  [3:0] dly_q;

	// pins are asynchronous; two stages before any logic looks at them
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			sync1_q <= 4'hF;
			sync2_q <= 4'hF;
			dly_q   <= 4'hF;
		end else begin
			sync1_q <= {wp_n_i, si_i, sclk_i, cs_n_i};
			sync2_q <= sync1_q;
			dly_q   <= sync2_q;
		end
	end

	wire cs_n_s    = sync2_q[0];
	wire sclk_s    = sync2_q[1];
	wire si_s      = sync2_q[2];
	wire wp_n_s    = sync2_q[3];
	wire cs_fall   = ~cs_n_s & dly_q[0];
	wire cs_rise   = cs_n_s & ~dly_q[0];
	wire sclk_rise = sclk_s & ~dly_q[1] & ~cs_n_s;
	wire sclk_fall = ~sclk_s & dly_q[1] & ~cs_n_s;

	////////////////////////////////////////////////////////////////////////
	// framing state

	reg  [5:0]  state_q;
	reg  [7:0]  opc_q;
	reg  [7:0]  shift_q;
	reg  [2:0]  bit_cnt_q;
	reg  [2:0]  byte_cnt_q;
	reg  [23:0] addr_q;
	reg  [7:0]  sr_lo_q;
	reg  [7:0]  sr_hi_q;
	reg  [2:0]  tx_idx_q;
	reg         rd_hi_q;

	// status fields
	reg         wel_q;
	reg         vol_we_q;
	reg  [4:0]  bp_q;
	reg  [1:0]  srp_q;
	reg  [2:0]  lock_q;
	reg         cmp_q;
	reg         sus_er_q;
	reg         sus_pg_q;
	reg  [2:0]  run_kind_q;

	wire        byte_done = sclk_rise & (bit_cnt_q == 3'd7);
	wire [7:0]  new_byte  = {shift_q[6:0], si_s};
	wire        boundary  = (bit_cnt_q == 3'd0);

	// opcode classes
	wire is_prog  = (opc_q == `SPF_OP_PROG) | (opc_q == `SPF_OP_DPROG);
	wire is_erase = (opc_q == `SPF_OP_SE_HALF) | (opc_q == `SPF_OP_SE_4K) |
		(opc_q == `SPF_OP_BE_32K) | (opc_q == `SPF_OP_BE_64K);
	reg  [2:0]  kind;
	wire        prot;

	// operation kind from the opcode
	always @* begin
		case (opc_q)
			`SPF_OP_SE_HALF: kind = `SPF_KIND_E_HALF;
			`SPF_OP_SE_4K:   kind = `SPF_KIND_E_4K;
			`SPF_OP_BE_32K:  kind = `SPF_KIND_E_32K;
			`SPF_OP_BE_64K:  kind = `SPF_KIND_E_64K;
			default:         kind = `SPF_KIND_PROG;
		endcase
	end

	spf_prot u_prot (
		.bp_i   (bp_q),
		.cmp_i  (cmp_q),
		.kind_i (kind),
		.addr_i (addr_q),
		.prot_o (prot)
	);

	////////////////////////////////////////////////////////////////////////
	// protection decisions

	reg sr_unlock;

	// status write lock from the protect pair and the protect pin
	always @* begin
		case (srp_q)
			2'b00:   sr_unlock = 1'b1;
			2'b01:   sr_unlock = wp_n_s;
			2'b10:   sr_unlock = 1'b0;
			default: sr_unlock = 1'b0;
		endcase
	end

	// a write also needs the latch (or, for status, the volatile enable) and an idle array engine
	wire sr_ok  = (wel_q | vol_we_q) & sr_unlock & ~busy_i;
	wire arr_ok = wel_q & ~prot & ~busy_i;
	wire sr8    = boundary & (byte_cnt_q == `SPF_SR8_BYTES);
	wire sr16   = boundary & (byte_cnt_q == `SPF_SR16_BYTES);
	wire one_b  = boundary & (byte_cnt_q == 3'd1);
	wire prog_go  = is_prog & boundary &
		(byte_cnt_q >= `SPF_PROG_MIN) & arr_ok;
	wire erase_go = is_erase & boundary &
		(byte_cnt_q == `SPF_ERASE_BYTES) & arr_ok;
	wire exec     = cs_rise & ~state_q[0];

	////////////////////////////////////////////////////////////////////////
	// frame sequencer: opcode, address and data bytes

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			state_q    <= ST_IDLE;
			opc_q      <= 8'h00;
			shift_q    <= 8'h00;
			bit_cnt_q  <= 3'd0;
			byte_cnt_q <= 3'd0;
			addr_q     <= 24'h00_0000;
			sr_lo_q    <= 8'h00;
			sr_hi_q    <= 8'h00;
			rd_hi_q    <= 1'b0;
		end else if (cs_rise) begin
			// select high ends every frame whatever its state
			state_q <= ST_IDLE;
		end else if (cs_fall) begin
			state_q    <= ST_OPC;
			bit_cnt_q  <= 3'd0;
			byte_cnt_q <= 3'd0;
			opc_q      <= 8'h00;
		end else if (sclk_rise && !state_q[0]) begin
			shift_q   <= new_byte;
			bit_cnt_q <= bit_cnt_q + 3'd1;
			if (byte_done && byte_cnt_q != 3'd7)
				byte_cnt_q <= byte_cnt_q + 3'd1;
			if (byte_done) begin
				case (state_q)
					ST_OPC: begin
						opc_q <= new_byte;
						case (new_byte)
							`SPF_OP_RDSR_LO: begin
								state_q <= ST_SINK;
								rd_hi_q <= 1'b0;
							end
							`SPF_OP_RDSR_HI: begin
								state_q <= ST_SINK;
								rd_hi_q <= 1'b1;
							end
							`SPF_OP_STATUS_WRITE_CMD:    state_q <= ST_STAT;
							`SPF_OP_PROG,
							`SPF_OP_DPROG,
							`SPF_OP_SE_HALF,
							`SPF_OP_SE_4K,
							`SPF_OP_BE_32K,
							`SPF_OP_BE_64K:  state_q <= ST_ADDR;
							default:         state_q <= ST_SINK;
						endcase
					end
					ST_ADDR: begin
						// address comes msb byte first
						addr_q <= {addr_q[15:0], new_byte};
						if (byte_cnt_q == `SPF_ADDR_BYTES)
							state_q <= ST_DATA;
					end
					ST_STAT: begin
						if (byte_cnt_q == 3'd1)
							sr_lo_q <= new_byte;
						if (byte_cnt_q == 3'd2)
							sr_hi_q <= new_byte;
					end
					ST_DATA: ;
					ST_SINK: ;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status register fields and command execution at select high

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			wel_q    <= 1'b0;
			vol_we_q <= 1'b0;
			bp_q     <= `SPF_RST_BP;
			srp_q    <= `SPF_RST_SRP;
			lock_q   <= `SPF_RST_LOCK;
			cmp_q    <= `SPF_RST_CMP;
			sus_er_q <= 1'b0;
			sus_pg_q <= 1'b0;
		end else begin
			// clears first, so a set in the same cycle wins
			if (op_done_i || pwr_cycle_i)
				wel_q <= 1'b0;
			if (pwr_cycle_i) begin
				vol_we_q <= 1'b0;
				sus_er_q <= 1'b0;
				sus_pg_q <= 1'b0;
				if (srp_q == 2'b10)
					srp_q <= 2'b00;
			end
			if (exec && opc_q == `SPF_OP_WRITE_DISABLE_CMD && one_b)
				wel_q <= 1'b0;
			if (exec && opc_q == `SPF_OP_WRITE_ENABLE_CMD && one_b)
				wel_q <= 1'b1;
			if (exec && opc_q == `SPF_OP_VOL_WE && one_b)
				vol_we_q <= 1'b1;
			// status write; bits 15, 10, 9, 1 and 0 are not writable
			if (exec && state_q == ST_STAT && (sr8 || sr16) && sr_ok) begin
				bp_q     <= sr_lo_q[6:2];
				srp_q[0] <= sr_lo_q[7];
				wel_q    <= 1'b0;
				vol_we_q <= 1'b0;
				if (sr8) begin
					cmp_q <= 1'b0;
				end else begin
					srp_q[1] <= sr_hi_q[0];
					lock_q   <= lock_q | sr_hi_q[5:3];
					cmp_q    <= sr_hi_q[6];
				end
			end
			if (exec && (prog_go || erase_go))
				wel_q <= 1'b0;
			// suspend only means something while the engine is busy
			if (exec && one_b && busy_i && (opc_q == `SPF_OP_SUSP_A ||
				opc_q == `SPF_OP_SUSP_B)) begin
				if (run_kind_q == `SPF_KIND_PROG)
					sus_pg_q <= 1'b1;
				else
					sus_er_q <= 1'b1;
			end
			if (exec && one_b && (opc_q == `SPF_OP_RESM_A ||
				opc_q == `SPF_OP_RESM_B)) begin
				sus_er_q <= 1'b0;
				sus_pg_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// requests to the array engine

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			op_go_o     <= 1'b0;
			op_kind_o   <= `SPF_KIND_PROG;
			op_addr_o   <= 24'h00_0000;
			run_kind_q  <= `SPF_KIND_PROG;
			prog_data_o <= 8'h00;
			prog_vld_o  <= 1'b0;
			crm_reset_o <= 1'b0;
		end else begin
			op_go_o     <= 1'b0;
			prog_vld_o  <= 1'b0;
			crm_reset_o <= 1'b0;
			// data bytes go out as taken; only op_go commits them
			if (sclk_rise && byte_done && state_q == ST_DATA && is_prog &&
				!cs_rise) begin
				prog_data_o <= new_byte;
				prog_vld_o  <= 1'b1;
			end
			if (exec && (prog_go || erase_go)) begin
				op_go_o    <= 1'b1;
				op_kind_o  <= kind;
				op_addr_o  <= addr_q;
				run_kind_q <= kind;
			end
			if (exec && opc_q == `SPF_OP_CRMR && one_b)
				crm_reset_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status read output and status word

	wire [15:0] sr_word = {sus_er_q, cmp_q, lock_q, sus_pg_q, 1'b0,
		srp_q[1], srp_q[0], bp_q, wel_q, busy_i};
	wire [7:0]  rd_byte = rd_hi_q ? sr_word[15:8] : sr_word[7:0];
	wire        rd_act  = (opc_q == `SPF_OP_RDSR_LO) |
		(opc_q == `SPF_OP_RDSR_HI);

	// bits shift out on falling edges; the byte is re-read each pass
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			so_o     <= 1'b0;
			so_oe_o  <= 1'b0;
			tx_idx_q <= 3'd0;
			status_o <= 16'h0000;
		end else begin
			status_o <= sr_word;
			if (cs_rise || cs_fall) begin
				so_oe_o  <= 1'b0;
				tx_idx_q <= 3'd0;
			end else if (sclk_fall && state_q == ST_SINK && rd_act) begin
				so_o     <= rd_byte[3'd7 - tx_idx_q];
				so_oe_o  <= 1'b1;
				tx_idx_q <= tx_idx_q + 3'd1;
			end
		end
	end

endmodule
`default_nettype wire

// [src/spf_consts.vh]
// spf_consts.vh: opcodes, status bit positions, reset values and kinds
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH

// opcodes
`define SPF_OP_WRITE_ENABLE_CMD      8'h06
`define SPF_OP_WRITE_DISABLE_CMD      8'h04
`define SPF_OP_VOL_WE    8'h50
`define SPF_OP_RDSR_LO   8'h05
`define SPF_OP_RDSR_HI   8'h35
`define SPF_OP_STATUS_WRITE_CMD      8'h01
`define SPF_OP_READ      8'h03
`define SPF_OP_FREAD     8'h0B
`define SPF_OP_DREAD     8'h3B
`define SPF_OP_DIOREAD   8'hBB
`define SPF_OP_CRMR      8'hFF
`define SPF_OP_PROG      8'h02
`define SPF_OP_DPROG     8'hA2
`define SPF_OP_SE_HALF   8'h8A
`define SPF_OP_SE_4K     8'h20
`define SPF_OP_BE_32K    8'h52
`define SPF_OP_BE_64K    8'hD8
`define SPF_OP_SUSP_A    8'h75
`define SPF_OP_SUSP_B    8'hB0
`define SPF_OP_RESM_A    8'h7A
`define SPF_OP_RESM_B    8'h30

// status word bit positions
`define SPF_SR_WIP       0
`define SPF_SR_WEL       1
`define SPF_SR_BP_LSB    2
`define SPF_SR_SRP_LO    7
`define SPF_SR_SRP_HI    8
`define SPF_SR_SUS_PG    10
`define SPF_SR_LOCK_LSB  11
`define SPF_SR_CMP       14
`define SPF_SR_SUS_ER    15

// reset values of the status fields
`define SPF_RST_BP       5'h00
`define SPF_RST_SRP      2'h0
`define SPF_RST_LOCK     3'h0
`define SPF_RST_CMP      1'b0

// byte counts of the frames
`define SPF_ADDR_BYTES   3'd3
`define SPF_SR8_BYTES    3'd2
`define SPF_SR16_BYTES   3'd3
`define SPF_ERASE_BYTES  3'd4
`define SPF_PROG_MIN     3'd5

// operation kinds handed to the array engine
`define SPF_KIND_PROG    3'd0
`define SPF_KIND_E_HALF  3'd1
`define SPF_KIND_E_4K    3'd2
`define SPF_KIND_E_32K   3'd3
`define SPF_KIND_E_64K   3'd4

`endif

// [src/spf_prot.v]
// spf_prot.v: block-protect area decode and overlap check for one operation
`timescale 1ns/1ps
`default_nettype none
`include "spf_consts.vh"

module spf_prot (
	// protection setting
	input  wire [4:0]  bp_i,
	input  wire        cmp_i,
	// operation
	input  wire [2:0]  kind_i,
	input  wire [23:0] addr_i,
	// result
	output reg         prot_o
);

	// all ranges are in 4KB units, 128 units cover the array
	reg  [7:0] size;
	reg        all;
	reg  [7:0] lo;
	reg  [7:0] hi;
	reg  [7:0] s;
	reg  [7:0] e;
	wire [7:0] u = {1'b0, addr_i[18:12]};

	// protected range from the block-protect bits
	always @* begin
		size = 8'h00;
		all  = 1'b0;
		if (bp_i[2:0] == 3'b000) begin
			size = 8'h00;
		end else if (!bp_i[4]) begin
			if (bp_i[2])
				all = 1'b1;
			else
				size = 8'h08 << bp_i[1:0];
		end else begin
			case (bp_i[2:0])
				3'b001:  size = 8'h01;
				3'b010:  size = 8'h02;
				3'b011:  size = 8'h04;
				3'b111:  all  = 1'b1;
				default: size = 8'h08;
			endcase
		end
		lo = bp_i[3] ? 8'h00 : (8'h80 - size);
		hi = bp_i[3] ? size : 8'h80;
		if (all) begin
			lo = 8'h00;
			hi = 8'h80;
		end
	end

	// range touched by the operation; erase blocks are aligned
	always @* begin
		case (kind_i)
			`SPF_KIND_E_32K: s = {u[7:3], 3'b000};
			`SPF_KIND_E_64K: s = {u[7:4], 4'b0000};
			default:         s = u;
		endcase
		case (kind_i)
			`SPF_KIND_E_32K: e = s + 8'h08;
			`SPF_KIND_E_64K: e = s + 8'h10;
			default:         e = s + 8'h01;
		endcase
		// complement protects everything outside the range
		if (cmp_i)
			prot_o = (s < lo) || (e > hi);
		else
			prot_o = (s < hi) && (e > lo);
	end

endmodule
`default_nettype wire

// [verif/spf_frame_checker.sv]
// spf_frame_checker.sv: port assertions for the frame and status logic
`timescale 1ns/1ps
`default_nettype none
module spf_frame_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        nrst_i,
	// observed ports
	input wire logic        cs_n_i,
	input wire logic        busy_i,
	input wire logic        so_oe_o,
	input wire logic        op_go_o,
	input wire logic        prog_vld_o,
	input wire logic        crm_reset_o,
	input wire logic [15:0] status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////
	// a start needs the latch, shown in the status word three cycles before the start
	go_latch_a: assert property (op_go_o |-> $past(status_o[1], 3))
		else $error("start without write enable");
	go_clear_a: assert property (op_go_o |-> ##[1:3] !status_o[1])
		else $error("latch kept after start");
	// starts only once the select is high again, and as single pulses
	go_end_a: assert property ((op_go_o || crm_reset_o) |->
		cs_n_i && $past(cs_n_i, 2) && !$past(op_go_o || crm_reset_o))
		else $error("start outside frame end");
	byte_pulse_a: assert property (prog_vld_o |->
		!$past(cs_n_i, 2) ##1 !prog_vld_o)
		else $error("data byte pulse misplaced");
	// status word contents
	wip_mirror_a: assert property (status_o[9] == 1'b0 &&
		status_o[0] == $past(busy_i))
		else $error("busy bit or reserved bit wrong");
	lock_keep_a: assert property (($past(status_o[13:11]) &
		~status_o[13:11]) == 3'b000)
		else $error("security lock cleared");
	otp_keep_a: assert property ($past(status_o[8:7]) == 2'b11 |->
		status_o[8:7] == 2'b11)
		else $error("permanent protection changed");
	// output driver must be off once the select has settled high
	oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
		else $error("output driven while deselected");
	cover property (op_go_o);
	cover property (prog_vld_o);
	cover property (crm_reset_o);
endmodule
bind spf_frame spf_frame_checker chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.cs_n_i(cs_n_i), .busy_i(busy_i), .so_oe_o(so_oe_o), .op_go_o(op_go_o),
	.prog_vld_o(prog_vld_o), .crm_reset_o(crm_reset_o), .status_o(status_o));
`default_nettype wire

// [verif/spf_host.sv]
// spf_host.sv: host model driving select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module spf_host (
	// serial pins
	output var logic        cs_n_o,
	output var logic        sclk_o,
	output var logic        si_o,
	input  wire logic       so_i
);
	localparam int HALF = 40; // half of the 80 ns serial clock
	logic [15:0] rx_q;
	// clock stands low and select high outside frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b1;
	end
	////////////////////////////////////////////////////////////
	// one frame of nb bits from the top of tx; data moves on falls
	task automatic xfer(input logic [47:0] tx, input int nb);
		cs_n_o = 1'b0;
		for (int i = 0; i < nb; i++) begin
			si_o = tx[47-i];
			#HALF sclk_o = 1'b1;
			// sample late in the high phase, well clear of the next shift
			#HALF rx_q = {rx_q[14:0], so_i};
			sclk_o = 1'b0;
		end
		#HALF cs_n_o = 1'b1;
		si_o = ~si_o; // a released line keeps no stale value
		#(8*HALF);
	endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// testbench.sv: scenarios for the serial flash frame and status logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// drives and observed pins
	logic             clk_i, nrst_i, wp_n_i, busy_i;
	logic [1:0]       ev;
	wire logic        cs_n, sclk, si, so, so_oe, go, vld, crm;
	wire logic [2:0]  kind;
	wire logic [23:0] addr;
	wire logic [7:0]  pdata;
	wire logic [15:0] st;
	int               err_total = 0, n_checks = 0, go_n, vld_n, crm_n;
	logic [2:0]       go_kind;
	logic [23:0]      go_addr;
	spf_frame dut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
		.sclk_i(sclk), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
		.so_oe_o(so_oe), .busy_i(busy_i), .op_done_i(ev[0]),
		.pwr_cycle_i(ev[1]), .op_go_o(go), .op_kind_o(kind),
		.op_addr_o(addr), .prog_data_o(pdata), .prog_vld_o(vld),
		.crm_reset_o(crm), .status_o(st));
	// an undriven output shows the opposite of its last bit to the host
	spf_host host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
		.so_i(so_oe ? so : ~so));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// count the one-cycle pulses so scenarios can judge them afterwards
	always @(posedge clk_i) begin
		if (go === 1'b1) begin
			go_n <= go_n + 1;
			go_kind <= kind;
			go_addr <= addr;
		end
		if (vld === 1'b1 && pdata === 8'h5A)
			vld_n <= vld_n + 1;
		if (crm === 1'b1)
			crm_n <= crm_n + 1;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [23:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one frame; pulse counts restart for each
	task automatic put(input logic [47:0] tx, input int nb);
		@(posedge clk_i);
		#1 go_n = 0;
		vld_n = 0;
		crm_n = 0;
		host.xfer(tx, nb);
	endtask
	task automatic wput(input logic [47:0] tx, input int nb);
		put(48'h0600_0000_0000, 8);
		put(tx, nb);
	endtask
	task automatic pulse(input logic [1:0] m);
		@(posedge clk_i);
		#1 ev = m;
		@(posedge clk_i);
		#1 ev = 2'b00;
		repeat (8) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_latch;
		chk("status", 16'h0000, st);
		put(48'h0104_4800_0000, 24);
		chk("status", 16'h0000, st);
		put(48'h0600_0000_0000, 9);
		chk("status", 16'h0000, st);
		put(48'h0600_0000_0000, 8);
		chk("status", 16'h0002, st);
		put(48'h0500_0000_0000, 24);
		chk("low read", 16'h0202, host.rx_q);
		// a read cut mid byte must not shift the next read
		put(48'h0500_0000_0000, 13);
		put(48'h0500_0000_0000, 24);
		chk("low read", 16'h0202, host.rx_q);
		pulse(2'b01);
		chk("status", 16'h0000, st);
		wput(48'h0400_0000_0000, 8);
		chk("status", 16'h0000, st);
		put(48'h5000_0000_0000, 8);
		put(48'h0104_4800_0000, 24);
		chk("status", 16'h4804, st);
		put(48'h3500_0000_0000, 24);
		chk("high read", 16'h4848, host.rx_q);
	endtask
	// complement on, lowest block-protect code: lower seven eighths
	task automatic t_prot;
		wput(48'h2007_0000_0000, 32);
		chk("starts", 1, go_n);
		chk("kind", 2, go_kind);
		chk("addr", 24'h07_0000, go_addr);
		wput(48'h2000_0000_0000, 32);
		chk("starts", 0, go_n);
		chk("status", 16'h4806, st);
		put(48'h0104_0000_0000, 16);
		chk("status", 16'h0804, st);
		wput(48'h0100_0000_0000, 24);
		chk("status", 16'h0800, st);
	endtask
	task automatic t_ops;
		logic [7:0] opc [6] = '{8'h02, 8'hA2, 8'h8A, 8'h20, 8'h52, 8'hD8};
		for (int i = 0; i < 6; i++) begin
			wput({opc[i], 24'h01_2300, 8'h5A, 8'h00}, i < 2 ? 40 : 32);
			chk("starts", 1, go_n);
			chk("kind", i < 2 ? 0 : i - 1, go_kind);
			chk("addr", 24'h01_2300, go_addr);
			chk("bytes", i < 2, vld_n);
			chk("status", 16'h0800, st);
		end
		wput(48'h0200_0100_A500, 36);
		chk("starts", 0, go_n);
		chk("status", 16'h0802, st);
		put(48'h2000_0100_0000, 40);
		chk("starts", 0, go_n);
		put(48'h0400_0000_0000, 8);
	endtask
	task automatic t_srp;
		wput(48'h0180_0000_0000, 24);
		chk("status", 16'h0880, st);
		@(posedge clk_i);
		#1 wp_n_i = 1'b0;
		wput(48'h0184_0000_0000, 24);
		chk("status", 16'h0880, st & 16'hFFFC);
		@(posedge clk_i);
		#1 wp_n_i = 1'b1;
		wput(48'h0100_0100_0000, 24);
		chk("status", 16'h0900, st);
		wput(48'h0100_0000_0000, 24);
		chk("status", 16'h0900, st & 16'hFFFC);
		pulse(2'b10);
		chk("status", 16'h0800, st);
		wput(48'h0180_0100_0000, 24);
		wput(48'h0100_0000_0000, 24);
		chk("status", 16'h0980, st & 16'hFFFC);
	endtask
	// last start was a 64K erase, so suspend marks the erase flag
	task automatic t_sus;
		@(posedge clk_i);
		#1 busy_i = 1'b1;
		put(48'h0400_0000_0000, 8);
		put(48'h7500_0000_0000, 8);
		chk("status", 16'h8981, st);
		put(48'h7A00_0000_0000, 8);
		chk("status", 16'h0981, st);
		@(posedge clk_i);
		#1 busy_i = 1'b0;
		put(48'hFF00_0000_0000, 16);
		chk("resets", 0, crm_n);
		put(48'hFF00_0000_0000, 8);
		chk("resets", 1, crm_n);
		// program suspend, cleared once by power cycle, once by resume
		wput({8'h02, 24'h01_2300, 8'h5A, 8'h00}, 40);
		chk("starts", 1, go_n);
		@(posedge clk_i);
		#1 busy_i = 1'b1;
		put(48'hB000_0000_0000, 8);
		chk("status", 16'h0D81, st);
		pulse(2'b10);
		chk("status", 16'h0981, st);
		put(48'hB000_0000_0000, 8);
		chk("status", 16'h0D81, st);
		put(48'h3000_0000_0000, 8);
		chk("status", 16'h0981, st);
		@(posedge clk_i);
		#1 busy_i = 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		nrst_i = 1'b0;
		wp_n_i = 1'b1;
		busy_i = 1'b0;
		ev = 2'b00;
		repeat (4) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		t_latch;
		t_prot;
		t_ops;
		t_srp;
		t_sus;
		print_verdict;
	end
	// cut a hang short well past the expected run length
	initial begin
		#600_000;
		err_total++;
		print_verdict;
	end
endmodule
`default_nettype wire
